// ### hdl/cef_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "cef_defs.svh"

module cef_flags #(
    parameter int INT_PULSE_CYC = `CEF_INT_PULSE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire cef_pkg::cef_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // charger status
    input wire cef_pkg::cef_status_t status_async,
    input wire logic [2:0] charge_state_field,
    // outputs
    output logic int_pulse,
    output logic safety_timer_rst
);
    import cef_pkg::*;

    localparam int NST = $bits(cef_status_t);

    generate
        if (INT_PULSE_CYC < 1 || INT_PULSE_CYC > 65535) begin : g_chk
            $error("INT_PULSE_CYC out of range");
        end
    endgenerate

    logic [NST-1:0] s1_ff, s2_ff, s3_ff, filt_ff, prev_ff, nxt_filt;
    logic [2:0] chg_prev_ff, prime_ff;
    logic primed;
    logic [7:0] evt_flags_ff, flt_flags_ff, evt_mask_ff, flt_mask_ff;
    logic [7:0] evt_set, flt_set, rdata_ff;
    logic [7:0] nxt_evt_flags, nxt_flt_flags;
    logic rvalid_ff, tmr_rst_ff;
    logic rd_evt, rd_flt, reg_rst, any_int;
    logic [15:0] cnt_ff;
    cef_int_state_t state_ff;

    // three-stage synchroniser; stage one feeds stage two only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= status_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // accept a new level only once stages two and three agree
    assign nxt_filt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            filt_ff <= '0;
            prev_ff <= '0;
        end else begin
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    // charge state comes from same-clock logic, so no synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chg_prev_ff <= 3'h0;
        end else begin
            chg_prev_ff <= charge_state_field;
        end
    end

    // hold off edge detection until the pipes hold real levels,
    // otherwise a level already high at reset would look like an edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prime_ff <= 3'h0;
        end else if (!primed) begin
            prime_ff <= prime_ff + 3'h1;
        end
    end
    assign primed = (prime_ff == `CEF_PRIME_CYC);

    // edge sources in register bit order
    always_comb begin
        evt_set = 8'h00;
        flt_set = 8'h00;
        if (primed) begin
            evt_set[7] = filt_ff[NST-1] ^ prev_ff[NST-1];
            evt_set[6:2] = filt_ff[NST-2:NST-6] & ~prev_ff[NST-2:NST-6];
            evt_set[0] = (charge_state_field != chg_prev_ff);
            flt_set[7:1] = filt_ff[6:0] & ~prev_ff[6:0];
        end
    end

    // register port decode
    assign rd_evt = reg_req.rd && (reg_req.addr == `CEF_ADDR_EVT_FLAGS);
    assign rd_flt = reg_req.rd && (reg_req.addr == `CEF_ADDR_FLT_FLAGS);
    assign reg_rst = reg_req.wr && (reg_req.addr == `CEF_ADDR_PART_INFO)
                     && reg_req.wdata[`CEF_BIT_REG_RST];

    // set wins over the clearing read; masks never stop latching
    assign nxt_evt_flags = ((rd_evt ? 8'h00 : evt_flags_ff) | evt_set)
                           & ~`CEF_EVT_RSVD_MASK;
    assign nxt_flt_flags = ((rd_flt ? 8'h00 : flt_flags_ff) | flt_set)
                           & ~`CEF_FLT_RSVD_MASK;

    // flag registers; no watchdog reset input, so expiry only sets its event flag
    always_ff @(posedge core_clk) begin
        if (!rst_n || reg_rst) begin
            evt_flags_ff <= `CEF_FLAGS_RST;
            flt_flags_ff <= `CEF_FLAGS_RST;
        end else begin
            evt_flags_ff <= nxt_evt_flags;
            flt_flags_ff <= nxt_flt_flags;
        end
    end

    // mask registers
    always_ff @(posedge core_clk) begin
        if (!rst_n || reg_rst) begin
            evt_mask_ff <= `CEF_MASK_RST;
            flt_mask_ff <= `CEF_MASK_RST;
        end else if (reg_req.wr) begin
            if (reg_req.addr == `CEF_ADDR_EVT_MASK) begin
                evt_mask_ff <= reg_req.wdata & ~`CEF_EVT_RSVD_MASK;
            end
            if (reg_req.addr == `CEF_ADDR_FLT_MASK) begin
                flt_mask_ff <= reg_req.wdata & ~`CEF_FLT_RSVD_MASK;
            end
        end
    end

    // read data, one cycle after the strobe; reset command bit reads zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_req.rd;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    `CEF_ADDR_EVT_FLAGS: rdata_ff <= evt_flags_ff;
                    `CEF_ADDR_FLT_FLAGS: rdata_ff <= flt_flags_ff;
                    `CEF_ADDR_EVT_MASK: rdata_ff <= evt_mask_ff;
                    `CEF_ADDR_FLT_MASK: rdata_ff <= flt_mask_ff;
                    `CEF_ADDR_PART_INFO: rdata_ff <= {1'b0, `CEF_PART_ID};
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // safety timer reset pulse follows the command by one cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tmr_rst_ff <= 1'b0;
        end else begin
            tmr_rst_ff <= reg_rst;
        end
    end
    assign safety_timer_rst = tmr_rst_ff;

    // any unmasked edge; a new one during a pulse restarts the width
    assign any_int = |(evt_set & ~evt_mask_ff) | |(flt_set & ~flt_mask_ff);

    // fixed-width interrupt pulse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= CEF_IDLE;
            cnt_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                CEF_IDLE: begin
                    if (any_int) begin
                        state_ff <= CEF_PULSE;
                        cnt_ff <= 16'(INT_PULSE_CYC - 1);
                    end
                end
                CEF_PULSE: begin
                    if (any_int) begin
                        cnt_ff <= 16'(INT_PULSE_CYC - 1);
                    end else if (cnt_ff == 16'h0000) begin
                        state_ff <= CEF_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                default: begin
                    state_ff <= CEF_IDLE;
                    cnt_ff <= 16'h0000;
                end
            endcase
        end
    end
    assign int_pulse = (state_ff == CEF_PULSE);

    // checks
    sequence s_quiet_evt_read;
        rd_evt && !reg_rst && (evt_set == 8'h00);
    endsequence

    sequence s_quiet_flt_read;
        rd_flt && !reg_rst && (flt_set == 8'h00);
    endsequence

    property p_evt_rd_clear;
        @(posedge core_clk) disable iff (!rst_n)
        s_quiet_evt_read |=> (evt_flags_ff == 8'h00);
    endproperty
    a_evt_rd_clear: assert property (p_evt_rd_clear) else $error("event flags not cleared by read");

    property p_flt_rd_clear;
        @(posedge core_clk) disable iff (!rst_n)
        s_quiet_flt_read |=> (flt_flags_ff == 8'h00);
    endproperty
    a_flt_rd_clear: assert property (p_flt_rd_clear) else $error("fault flags not cleared by read");

    property p_pg_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        (primed && !reg_rst && (filt_ff[NST-1] != prev_ff[NST-1])) |=> evt_flags_ff[`CEF_BIT_PG];
    endproperty
    a_pg_toggle: assert property (p_pg_toggle) else $error("power-good toggle not flagged");

    property p_chg_change;
        @(posedge core_clk) disable iff (!rst_n)
        (primed && !reg_rst && $changed(charge_state_field)) |=> evt_flags_ff[`CEF_BIT_CHG];
    endproperty
    a_chg_change: assert property (p_chg_change) else $error("charge state change not flagged");

    property p_rsvd_zero;
        @(posedge core_clk) disable iff (!rst_n)
        !evt_flags_ff[1] && !evt_mask_ff[1] && !flt_flags_ff[0];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

    property p_wd_int;
        @(posedge core_clk) disable iff (!rst_n)
        (evt_set[`CEF_BIT_WD] && !evt_mask_ff[`CEF_BIT_WD]) |=> int_pulse;
    endproperty
    a_wd_int: assert property (p_wd_int) else $error("watchdog edge gave no pulse");

    property p_pg_masked;
        @(posedge core_clk) disable iff (!rst_n)
        (state_ff == CEF_IDLE && evt_set[`CEF_BIT_PG] && evt_mask_ff[`CEF_BIT_PG]
            && ((evt_set & ~evt_mask_ff) == 8'h00) && ((flt_set & ~flt_mask_ff) == 8'h00)) |=> !int_pulse;
    endproperty
    a_pg_masked: assert property (p_pg_masked) else $error("masked event pulsed interrupt");

    property p_pulse_width;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(int_pulse) |-> ($past(cnt_ff) == 16'h0000 && !$past(any_int));
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("interrupt pulse ended early");

    property p_reg_rst;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rst |=> (evt_mask_ff == 8'h00 && flt_mask_ff == 8'h00 && evt_flags_ff == 8'h00 && safety_timer_rst);
    endproperty
    a_reg_rst: assert property (p_reg_rst) else $error("register reset incomplete");

    property p_set_wins;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_evt && !reg_rst) |=> (evt_flags_ff == $past(evt_set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clearing read");

    property p_pg_int;
        @(posedge core_clk) disable iff (!rst_n)
        (evt_set[`CEF_BIT_PG] && !evt_mask_ff[`CEF_BIT_PG]) |=> int_pulse;
    endproperty
    a_pg_int: assert property (p_pg_int) else $error("power-good toggle gave no pulse");

    property p_chg_int;
        @(posedge core_clk) disable iff (!rst_n)
        (evt_set[`CEF_BIT_CHG] && !evt_mask_ff[`CEF_BIT_CHG]) |=> int_pulse;
    endproperty
    a_chg_int: assert property (p_chg_int) else $error("charge state change gave no pulse");

    property p_flt_int;
        @(posedge core_clk) disable iff (!rst_n)
        (|(flt_set & ~flt_mask_ff)) |=> int_pulse;
    endproperty
    a_flt_int: assert property (p_flt_int) else $error("unmasked fault edge gave no pulse");

    // masks only gate the pulse, so every edge must still land in its flag
    property p_flag_latch;
        @(posedge core_clk) disable iff (!rst_n)
        (!reg_rst && ((evt_set | flt_set) != 8'h00))
            |=> (((evt_flags_ff & $past(evt_set)) == $past(evt_set))
            && ((flt_flags_ff & $past(flt_set)) == $past(flt_set)));
    endproperty
    a_flag_latch: assert property (p_flag_latch) else $error("edge did not latch its flag");

    property p_flt_set_wins;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_flt && !reg_rst) |=> (flt_flags_ff == $past(flt_set));
    endproperty
    a_flt_set_wins: assert property (p_flt_set_wins) else $error("fault lost on clearing read");

    property p_flt_rst;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rst |=> (flt_flags_ff == 8'h00);
    endproperty
    a_flt_rst: assert property (p_flt_rst) else $error("fault flags kept over register reset");

    property p_pulse_start;
        @(posedge core_clk) disable iff (!rst_n)
        (state_ff == CEF_IDLE && any_int) |=> (int_pulse && cnt_ff == 16'(INT_PULSE_CYC - 1));
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("interrupt pulse did not start");

endmodule

`default_nettype wire

// ### hdl/cef_defs.svh
`ifndef CEF_DEFS_SVH
`define CEF_DEFS_SVH

// register offsets on the internal register port
`define CEF_ADDR_EVT_FLAGS 4'h9
`define CEF_ADDR_FLT_FLAGS 4'ha
`define CEF_ADDR_EVT_MASK 4'hb
`define CEF_ADDR_FLT_MASK 4'hc
`define CEF_ADDR_PART_INFO 4'hd

// reset values
`define CEF_FLAGS_RST 8'h00
`define CEF_MASK_RST 8'h00

// reserved bit positions, forced to zero
`define CEF_EVT_RSVD_MASK 8'h02
`define CEF_FLT_RSVD_MASK 8'h01

// field positions
`define CEF_BIT_PG 7
`define CEF_BIT_WD 3
`define CEF_BIT_CHG 0
`define CEF_BIT_REG_RST 7

// arbitrary neutral identity value for the part information field
`define CEF_PART_ID 7'h00

// interrupt pulse width
`define CEF_CLK_PERIOD_NS 10
`define CEF_INT_PULSE_NS 1000
`define CEF_INT_PULSE_CYC ((`CEF_INT_PULSE_NS + `CEF_CLK_PERIOD_NS - 1) / `CEF_CLK_PERIOD_NS)

// cycles after reset before edges are trusted (sync pipe plus filter and previous stages)
`define CEF_PRIME_CYC 3'd5

`endif

// ### hdl/cef_pkg.sv
`default_nettype none

package cef_pkg;

    // request from the serial-port register engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } cef_reg_req_t;

    // asynchronous charger status levels, msb first
    typedef struct packed {
        logic power_good_signal;
        logic input_current_regulation;
        logic input_voltage_regulation;
        logic thermal_regulation;
        logic watchdog_expired_status;
        logic termination;
        logic input_overvoltage;
        logic thermal_shutdown;
        logic battery_overvoltage;
        logic flying_cap_fault;
        logic safety_timer_expired;
        logic cap_precondition_status;
        logic weak_source_status;
    } cef_status_t;

    // interrupt pulse machine
    typedef enum logic [1:0] {
        CEF_IDLE = 2'b01,
        CEF_PULSE = 2'b10
    } cef_int_state_t;

endpackage

`default_nettype wire

// ### tb/cef_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cef_host_model (
    // clock
    input wire logic core_clk,
    // register port
    output cef_pkg::cef_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    import cef_pkg::*;

    // idle lines carry a junk pattern, never a plausible request
    initial reg_req = '{rd: 1'b0, wr: 1'b0, addr: 4'h5, wdata: 8'h5a};

    // one access per call, strobe held over exactly one rising edge
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge core_clk);
        reg_req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge core_clk);
        // answer stands one cycle only, so it is taken here or lost
        q = (!w && reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
        // released lines show the inverse so stale values are not mistaken for live ones
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

`default_nettype wire

// ### tb/charger_event_fault_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module charger_event_fault_flags_tb_top;
    import cef_pkg::*;

    localparam int PULSE = 4;
    logic core_clk;
    logic rst_n;
    cef_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    cef_status_t status_async;
    logic [2:0] charge_state_field;
    logic int_pulse;
    logic safety_timer_rst;
    logic [7:0] q;
    logic [7:0] r1;
    int failures;
    int check_count;

    // free-running clock
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    cef_flags #(.INT_PULSE_CYC(PULSE)) dut_u (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .status_async(status_async),
        .charge_state_field(charge_state_field),
        .int_pulse(int_pulse),
        .safety_timer_rst(safety_timer_rst)
    );

    cef_host_model host_u (
        .core_clk(core_clk),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        host_u.access(1'b0, a, 8'h00, d);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        host_u.access(1'b1, a, d, dummy);
    endtask

    // window covers sync delay plus the whole pulse
    task automatic count_pulse(output logic [7:0] n);
        n = 8'h00;
        repeat (14) begin
            @(negedge core_clk);
            if (int_pulse === 1'b1) n++;
        end
    endtask

    // index 0..12 is a status bit, 13 the charge state field
    task automatic ev(input int i, input logic m);
        logic [3:0] a;
        logic [7:0] e;
        logic [7:0] n;
        logic both;
        a = (i >= 7) ? 4'h9 : 4'ha;
        e = (i == 13) ? 8'h01 : (i >= 7) ? 8'h01 << (i - 5) : 8'h01 << (i + 1);
        both = (i >= 12);
        if (i == 13) charge_state_field = 3'h3;
        else status_async[i] = 1'b1;
        count_pulse(n);
        chk(n, m ? 8'h00 : 8'(PULSE));
        rd(a, q);
        chk(q, e);
        rd(a, q);
        chk(q, 8'h00);
        if (i == 13) charge_state_field = 3'h0;
        else status_async[i] = 1'b0;
        count_pulse(n);
        chk(n, (both && !m) ? 8'(PULSE) : 8'h00);
        rd(a, q);
        chk(q, both ? e : 8'h00);
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog, well beyond the roughly 1100 cycles the tests need
    initial begin
        #100000;
        failures++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        status_async = '0;
        charge_state_field = 3'h0;
        failures = 0;
        check_count = 0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        // edges are ignored while the detector primes
        repeat (8) @(negedge core_clk);
        rd(4'h9, q);
        chk(q, 8'h00);
        rd(4'ha, q);
        chk(q, 8'h00);
        rd(4'hb, q);
        chk(q, 8'h00);
        rd(4'hc, q);
        chk(q, 8'h00);
        rd(4'he, q);
        chk(q, 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, q);
        chk(q, 8'h00);
        wr(4'ha, 8'hff);
        rd(4'ha, q);
        chk(q, 8'h00);
        for (int i = 0; i < 14; i++) ev(i, 1'b0);
        wr(4'hb, 8'hff);
        rd(4'hb, q);
        chk(q, 8'hfd);
        wr(4'hc, 8'hff);
        rd(4'hc, q);
        chk(q, 8'hfe);
        for (int i = 0; i < 14; i++) ev(i, 1'b1);
        // slide a charge state change across the clearing read
        for (int k = 0; k < 6; k++) begin
            rd(4'h9, q);
            fork
                begin
                    repeat (k) @(negedge core_clk);
                    charge_state_field = charge_state_field + 3'h1;
                end
                rd(4'h9, r1);
            join
            repeat (10) @(negedge core_clk);
            rd(4'h9, q);
            chk(q | r1, 8'h01);
        end
        // register reset command with flags and masks set
        status_async.power_good_signal = 1'b1;
        status_async.input_overvoltage = 1'b1;
        repeat (14) @(negedge core_clk);
        wr(4'hd, 8'h80);
        chk({7'h00, safety_timer_rst}, 8'h01);
        @(negedge core_clk);
        chk({7'h00, safety_timer_rst}, 8'h00);
        rd(4'h9, q);
        chk(q, 8'h00);
        rd(4'ha, q);
        chk(q, 8'h00);
        rd(4'hb, q);
        chk(q, 8'h00);
        rd(4'hc, q);
        chk(q, 8'h00);
        rd(4'hd, q);
        chk(q & 8'h80, 8'h00);
        complete_run();
    end
endmodule

`default_nettype wire
